// File: bench/fcs_array_model.sv
// Behavioural flash array on the far side of the sequencer's array port.
// Assumes one clock; erase fills a whole sector with FFh, program only clears bits.
`timescale 1ns/1ps
`default_nettype none
module fcs_array_model #(
  parameter int BUSY_CYCLES = 6,
  parameter int SECTOR_BYTES = 4096
) (
  // Clock
  input wire logic clk_sys,
  // Sequencer side
  input wire logic [15:0] arrayRdAddr,
  input wire logic arrayWrite,
  input wire logic arrayErase,
  input wire logic [15:0] arrayOpAddr,
  input wire logic [7:0] arrayOpData,
  output logic [7:0] arrayRdata,
  output logic arrayBusy
);
  logic [7:0] mem [0:65535];
  int busyCnt = 0;

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hFF;
  end

  assign arrayRdata = mem[arrayRdAddr];
  assign arrayBusy = busyCnt != 0;

  // Programming ANDs into the cell, as real flash does
  always @(posedge clk_sys)
  begin
    if (arrayWrite)
      mem[arrayOpAddr] <= mem[arrayOpAddr] & arrayOpData;
    if (arrayErase)
      for (int i = 0; i < SECTOR_BYTES; i++)
        mem[(arrayOpAddr & ~16'(SECTOR_BYTES - 1)) + 16'(i)] <= 8'hFF;
    if (arrayWrite || arrayErase)
      busyCnt <= BUSY_CYCLES;
    else if (busyCnt > 0)
      busyCnt <= busyCnt - 1;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the flash command sequencer, CPU bus driven by tasks.
// Assumes the array model in fcs_array_model and a combinational boot ROM pattern.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys;
  logic rst_n;
  logic ctlWrite;
  logic [3:0] ctlField;
  fcs_pkg::fcs_bus_s cpuBus;
  logic serialModePin;
  logic [7:0] bootRdata, cpuRdata, arrayRdata, arrayOpData;
  logic bootSel, arrayBusy, arrayWrite, arrayErase, arrayOpBank, cmdUnlocked, opActive;
  logic [15:0] arrayRdAddr, arrayOpAddr;
  logic [7:0] r1, r2;
  int failCount = 0;
  int nChecks = 0;
  int nWr = 0;
  int nEr = 0;
  int cycles = 0;

  // Boot ROM content is a simple address pattern
  assign bootRdata = cpuBus.addr[7:0] ^ 8'h5A;

  fcs_sequencer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctlWrite(ctlWrite), .ctlField(ctlField),
    .cpuBus(cpuBus), .cpuRdata(cpuRdata), .serialModePin(serialModePin), .bootRdata(bootRdata),
    .bootSel(bootSel), .arrayRdata(arrayRdata), .arrayBusy(arrayBusy), .arrayRdAddr(arrayRdAddr),
    .arrayWrite(arrayWrite), .arrayErase(arrayErase), .arrayOpAddr(arrayOpAddr),
    .arrayOpBank(arrayOpBank), .arrayOpData(arrayOpData), .cmdUnlocked(cmdUnlocked),
    .opActive(opActive));

  fcs_array_model i_array (.clk_sys(clk_sys), .arrayRdAddr(arrayRdAddr), .arrayWrite(arrayWrite),
    .arrayErase(arrayErase), .arrayOpAddr(arrayOpAddr), .arrayOpData(arrayOpData),
    .arrayRdata(arrayRdata), .arrayBusy(arrayBusy));

  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ****
  // Checking and closing
  // ****
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Launch pulses counted and a hang cut short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (arrayWrite === 1'h1)
      nWr++;
    if (arrayErase === 1'h1)
      nEr++;
    if (cycles == 20000)
    begin
      failCount++;
      endSim();
    end
  end

  // ****
  // Bus tasks: control code is taken to run from RAM with interrupts off
  // ****
  task automatic setField(input logic [3:0] f);
    @(negedge clk_sys);
    ctlWrite = 1'h1;
    ctlField = f;
    @(negedge clk_sys);
    ctlWrite = 1'h0;
  endtask

  task automatic busWr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpuBus = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge clk_sys);
    cpuBus.wr = 1'h0;
  endtask

  task automatic busRd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    cpuBus = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    cpuBus.rd = 1'h0;
    d = cpuRdata;
  endtask

  task automatic seqWrite(input logic [15:0] a, input logic [7:0] d);
    busWr(16'hF555, 8'hAA);
    busWr(16'hFAAA, 8'h55);
    busWr(16'hF555, 8'hA0);
    busWr(a, d);
  endtask

  task automatic seqErasePrefix();
    busWr(16'hF555, 8'hAA);
    busWr(16'hFAAA, 8'h55);
    busWr(16'hF555, 8'h80);
    busWr(16'hF555, 8'hAA);
    busWr(16'hFAAA, 8'h55);
  endtask

  // Poll until two consecutive reads agree, bounded
  task automatic waitDone(input logic [15:0] a);
    logic [7:0] p;
    logic [7:0] q;
    int n;
    n = 0;
    busRd(a, p);
    busRd(a, q);
    while (p !== q && n < 40)
    begin
      p = q;
      busRd(a, q);
      n++;
    end
    check("opActive done", opActive, 16'h0000);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic tLocked();
    check("cmdUnlocked reset", cmdUnlocked, 16'h0000);
    setField(4'h5);
    check("cmdUnlocked other pattern", cmdUnlocked, 16'h0000);
    seqWrite(16'hE000, 8'h00);
    repeat (3) @(negedge clk_sys);
    check("writes while locked", 16'(nWr), 16'h0000);
  endtask

  task automatic tErase();
    setField(4'h3);
    check("cmdUnlocked", cmdUnlocked, 16'h0001);
    setField(4'h5);
    check("cmdUnlocked other", cmdUnlocked, 16'h0001);
    seqErasePrefix();
    busWr(16'hE123, 8'h30);
    check("arrayErase", arrayErase, 16'h0001);
    check("erase addr", arrayOpAddr, 16'hD123);
    busRd(16'hF555, r1);
    busRd(16'hF555, r2);
    check("status differs", 16'(r1 != r2), 16'h0001);
    check("status toggle", 16'(r1[6] ^ r2[6]), 16'h0001);
    check("first status byte", r1, 16'h00C0);
    waitDone(16'hF555);
    busRd(16'hE000, r1);
    check("erased", r1, 16'h00FF);
  endtask

  task automatic tWrite();
    seqWrite(16'hE000, 8'h3F);
    check("arrayWrite", arrayWrite, 16'h0001);
    check("write addr", arrayOpAddr, 16'hD000);
    check("write bank", arrayOpBank, 16'h0001);
    check("write data", arrayOpData, 16'h003F);
    busRd(16'hE000, r1);
    check("status not array", r1 & 8'hBF, 16'h0080);
    waitDone(16'hE000);
    busRd(16'hE000, r1);
    check("written", r1, 16'h003F);
    // Erase a sector that now holds data, so an erase that never lands shows up
    seqErasePrefix();
    busWr(16'hE800, 8'h30);
    check("erase sector addr", arrayOpAddr, 16'hD800);
    waitDone(16'hF555);
    busRd(16'hE000, r1);
    check("sector erased", r1, 16'h00FF);
  endtask

  task automatic tBroken();
    int w;
    int e;
    w = nWr;
    e = nEr;
    busWr(16'hF555, 8'hAA);
    busWr(16'hFAAA, 8'h55);
    busWr(16'hF555, 8'h12);
    busWr(16'hE001, 8'h00);
    seqErasePrefix();
    busWr(16'hE000, 8'h31);
    repeat (2) @(negedge clk_sys);
    check("broken write", 16'(nWr - w), 16'h0000);
    check("broken erase", 16'(nEr - e), 16'h0000);
    check("broken idle", opActive, 16'h0000);
  endtask

  task automatic tLock();
    int w;
    seqWrite(16'hE001, 8'h55);
    setField(4'hC);
    check("cmdUnlocked lock", cmdUnlocked, 16'h0000);
    check("op runs on after lock", opActive, 16'h0001);
    waitDone(16'hF555);
    busRd(16'hE001, r1);
    check("written before lock", r1, 16'h0055);
    w = nWr;
    seqWrite(16'hE002, 8'h00);
    repeat (2) @(negedge clk_sys);
    check("writes after lock", 16'(nWr - w), 16'h0000);
  endtask

  task automatic tSerial();
    serialModePin = 1'h1;
    repeat (4) @(negedge clk_sys);
    busRd(16'h7800, r1);
    check("boot low", r1, 16'h005A);
    busRd(16'h7FFF, r1);
    check("boot high", r1, 16'h00A5);
    check("bootSel in", bootSel, 16'h0001);
    busRd(16'h77FF, r1);
    check("below boot", r1, 16'h00FF);
    check("bootSel out", bootSel, 16'h0000);
    check("read translate", arrayRdAddr, 16'h67FF);
    setField(4'h3);
    seqWrite(16'h7900, 8'h12);
    check("serial write addr", arrayOpAddr, 16'h6900);
    check("serial write bank", arrayOpBank, 16'h0000);
    // Poll outside the boot window: reads inside it return boot ROM data, never status
    waitDone(16'hF555);
    setField(4'hC);
    serialModePin = 1'h0;
    repeat (3) @(negedge clk_sys);
    busRd(16'h7900, r1);
    check("serial written", r1, 16'h0012);
  endtask

  initial
  begin
    rst_n = 1'h0;
    ctlWrite = 1'h0;
    ctlField = 4'h0;
    cpuBus = '0;
    serialModePin = 1'h0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'h1;
    tLocked();
    tErase();
    tWrite();
    tBroken();
    tLock();
    tSerial();
    endSim();
  end
endmodule
`default_nettype wire

// File: rtl/fcs_addr_map.sv
// Address decoder of the flash command sequencer: boot ROM window and flash array translation.
// Assumes the serial programming mode level is already synchronised to the caller's clock.
`timescale 1ns/1ps
`default_nettype none
module fcs_addr_map (
  // Bus side
  input wire logic [15:0] cpuAddr,
  input wire logic serialMode,
  // Decoded side
  output logic bootSel,
  output logic flashSel,
  output logic [15:0] arrayAddr,
  output logic arrayBank
);

  // Boot ROM only shadows flash in serial mode; command targets always reach flash
  always_comb
  begin
    bootSel = serialMode && (cpuAddr >= fcs_pkg::BOOT_BASE) && (cpuAddr <= fcs_pkg::BOOT_LAST);
    flashSel = (cpuAddr >= fcs_pkg::FLASH_BASE);
    arrayAddr = 16'(cpuAddr - fcs_pkg::FLASH_BASE);
    arrayBank = arrayAddr[fcs_pkg::BANK_BIT];
  end

endmodule
`default_nettype wire

// File: rtl/fcs_pkg.sv
// Package for the flash command sequencer: command addresses, codes, patterns and shared types.
// Assumes an 8-bit CPU bus with 16-bit addresses on the same clock as the sequencer.
package fcs_pkg;

  // ************************************************************
  // Command-enable field patterns
  // ************************************************************
  localparam int unsigned CMD_FIELD_W = 4;
  localparam logic [3:0] CMD_UNLOCK = 4'h3;
  localparam logic [3:0] CMD_LOCK = 4'hC;

  // ************************************************************
  // Command sequence addresses and data codes
  // ************************************************************
  localparam logic [15:0] CMD_ADDR_A = 16'hF555;
  localparam logic [15:0] CMD_ADDR_B = 16'hFAAA;
  localparam logic [7:0] CODE_FIRST = 8'hAA;
  localparam logic [7:0] CODE_SECOND = 8'h55;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_WRITE_SETUP = 8'hA0;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;

  // ************************************************************
  // Memory map
  // ************************************************************
  localparam logic [15:0] FLASH_BASE = 16'h1000;
  localparam logic [15:0] BOOT_BASE = 16'h7800;
  localparam logic [15:0] BOOT_LAST = 16'h7FFF;
  localparam int unsigned BOOT_BYTES = 2048;
  localparam int unsigned BANK_BIT = 15;

  // ************************************************************
  // Status byte returned while an operation runs
  // ************************************************************
  localparam int unsigned STAT_TOGGLE_POS = 6;
  localparam int unsigned STAT_POLL_POS = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CYC1,
    ST_CYC2,
    ST_ERA3,
    ST_ERA4,
    ST_ERA5,
    ST_WR3,
    ST_LAUNCH,
    ST_BUSY
  } fcs_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fcs_bus_s;

endpackage

// File: rtl/fcs_sequencer.sv
// Flash command sequencer: lock, command decoding, array launch and status reads.
// Assumes the flash array raises arrayBusy one cycle after a launch pulse and returns read data combinationally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Command sequences are accepted only after the command-enable field is written with 0011B.
// - Writing 1100B into the command-enable field locks the controller so later sequences are ignored.
// - Sector erase is AAh@F555h, 55h@FAAAh, 80h@F555h, AAh@F555h, 55h@FAAAh, then 30h inside the sector.
// - Byte write is AAh@F555h, 55h@FAAAh, A0h@F555h, then the data byte at the destination.
// - A byte write reaches its location with no bank selected by software.
// - Reads of flash during an operation differ from read to read, and two equal reads mean done.
// - Flash reads during an operation return status instead of array contents.
// - In serial programming mode the 2048-byte boot ROM answers at 7800h to 7FFFh.
// - In serial programming mode flash is two banks and command addresses 1000h-FFFFh are translated.
module fcs_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command-enable field write
  input wire logic ctlWrite,
  input wire logic [3:0] ctlField,
  // CPU bus
  input wire fcs_pkg::fcs_bus_s cpuBus,
  output logic [7:0] cpuRdata,
  // Mode pin
  input wire logic serialModePin,
  // Boot ROM
  input wire logic [7:0] bootRdata,
  output logic bootSel,
  // Flash array
  input wire logic [7:0] arrayRdata,
  input wire logic arrayBusy,
  output logic [15:0] arrayRdAddr,
  output logic arrayWrite,
  output logic arrayErase,
  output logic [15:0] arrayOpAddr,
  output logic arrayOpBank,
  output logic [7:0] arrayOpData,
  // Status
  output logic cmdUnlocked,
  output logic opActive
);

  // ************************************************************
  // Mode pin synchroniser and address decode
  // ************************************************************
  logic serialMeta;
  logic serialMode;
  logic flashSel;
  logic rdBank;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serialMeta <= 1'b0;
      serialMode <= 1'b0;
    end
    else
    begin
      serialMeta <= serialModePin;
      serialMode <= serialMeta;
    end
  end

  fcs_addr_map uMap (
    .cpuAddr(cpuBus.addr),
    .serialMode(serialMode),
    .bootSel(bootSel),
    .flashSel(flashSel),
    .arrayAddr(arrayRdAddr),
    .arrayBank(rdBank)
  );

  function automatic logic hit(input fcs_pkg::fcs_bus_s b, input logic [15:0] a, input logic [7:0] d);
    hit = b.wr && (b.addr == a) && (b.wdata == d);
  endfunction

  // ************************************************************
  // Lock and command state
  // ************************************************************
  fcs_pkg::fcs_state_e state;
  fcs_pkg::fcs_state_e next_state;
  fcs_pkg::fcs_state_e restart;
  logic next_cmdUnlocked;
  logic next_arrayWrite;
  logic next_arrayErase;
  logic [15:0] next_arrayOpAddr;
  logic next_arrayOpBank;
  logic [7:0] next_arrayOpData;

  always_comb
  begin
    next_cmdUnlocked = cmdUnlocked;
    if (ctlWrite && ctlField == fcs_pkg::CMD_UNLOCK)
      next_cmdUnlocked = 1'b1;
    else if (ctlWrite && ctlField == fcs_pkg::CMD_LOCK)
      next_cmdUnlocked = 1'b0;
    // A broken pattern may itself be a valid first cycle, so it restarts instead of idling
    restart = hit(cpuBus, fcs_pkg::CMD_ADDR_A, fcs_pkg::CODE_FIRST) ? fcs_pkg::ST_CYC1 : fcs_pkg::ST_IDLE;
    next_state = state;
    next_arrayWrite = 1'b0;
    next_arrayErase = 1'b0;
    next_arrayOpAddr = arrayOpAddr;
    next_arrayOpBank = arrayOpBank;
    next_arrayOpData = arrayOpData;
    case (state)
      fcs_pkg::ST_IDLE:
        if (cmdUnlocked && cpuBus.wr)
          next_state = restart;
      fcs_pkg::ST_CYC1:
        if (cpuBus.wr)
          next_state = hit(cpuBus, fcs_pkg::CMD_ADDR_B, fcs_pkg::CODE_SECOND) ? fcs_pkg::ST_CYC2 : restart;
      fcs_pkg::ST_CYC2:
        if (hit(cpuBus, fcs_pkg::CMD_ADDR_A, fcs_pkg::CODE_ERASE_SETUP))
          next_state = fcs_pkg::ST_ERA3;
        else if (hit(cpuBus, fcs_pkg::CMD_ADDR_A, fcs_pkg::CODE_WRITE_SETUP))
          next_state = fcs_pkg::ST_WR3;
        else if (cpuBus.wr)
          next_state = restart;
      fcs_pkg::ST_ERA3:
        if (cpuBus.wr)
          next_state = hit(cpuBus, fcs_pkg::CMD_ADDR_A, fcs_pkg::CODE_FIRST) ? fcs_pkg::ST_ERA4 : fcs_pkg::ST_IDLE;
      fcs_pkg::ST_ERA4:
        if (cpuBus.wr)
          next_state = hit(cpuBus, fcs_pkg::CMD_ADDR_B, fcs_pkg::CODE_SECOND) ? fcs_pkg::ST_ERA5 : restart;
      fcs_pkg::ST_ERA5:
        if (cpuBus.wr && flashSel && cpuBus.wdata == fcs_pkg::CODE_SECTOR_ERASE)
        begin
          next_state = fcs_pkg::ST_LAUNCH;
          next_arrayErase = 1'b1;
          next_arrayOpAddr = arrayRdAddr;
          next_arrayOpBank = rdBank;
        end
        else if (cpuBus.wr)
          next_state = restart;
      fcs_pkg::ST_WR3:
        if (cpuBus.wr && flashSel)
        begin
          next_state = fcs_pkg::ST_LAUNCH;
          next_arrayWrite = 1'b1;
          next_arrayOpAddr = arrayRdAddr;
          next_arrayOpBank = rdBank;
          next_arrayOpData = cpuBus.wdata;
        end
        else if (cpuBus.wr)
          next_state = fcs_pkg::ST_IDLE;
      fcs_pkg::ST_LAUNCH:
        next_state = fcs_pkg::ST_BUSY;
      fcs_pkg::ST_BUSY:
        if (!arrayBusy)
          next_state = fcs_pkg::ST_IDLE;
      default:
        next_state = fcs_pkg::ST_IDLE;
    endcase
    // Locking abandons any partial sequence, but a launched operation still finishes
    if (!cmdUnlocked && state != fcs_pkg::ST_LAUNCH && state != fcs_pkg::ST_BUSY)
    begin
      next_state = fcs_pkg::ST_IDLE;
      next_arrayWrite = 1'b0;
      next_arrayErase = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= fcs_pkg::ST_IDLE;
      cmdUnlocked <= 1'b0;
      arrayWrite <= 1'b0;
      arrayErase <= 1'b0;
      arrayOpAddr <= 16'h0000;
      arrayOpBank <= 1'b0;
      arrayOpData <= 8'h00;
    end
    else
    begin
      state <= next_state;
      cmdUnlocked <= next_cmdUnlocked;
      arrayWrite <= next_arrayWrite;
      arrayErase <= next_arrayErase;
      arrayOpAddr <= next_arrayOpAddr;
      arrayOpBank <= next_arrayOpBank;
      arrayOpData <= next_arrayOpData;
    end
  end

  assign opActive = (state == fcs_pkg::ST_LAUNCH) || (state == fcs_pkg::ST_BUSY);

  // ************************************************************
  // Read path and status toggling
  // ************************************************************
  logic toggleBit;
  logic next_toggleBit;
  logic [7:0] next_cpuRdata;
  logic statusRead;

  always_comb
  begin
    statusRead = cpuBus.rd && !bootSel && flashSel && opActive;
    next_toggleBit = toggleBit;
    next_cpuRdata = cpuRdata;
    if (cpuBus.rd && bootSel)
      next_cpuRdata = bootRdata;
    else if (statusRead)
    begin
      // Any flash read outside the boot ROM window, vector fetches included, sees status here; software must keep interrupts off
      next_toggleBit = !toggleBit;
      next_cpuRdata = fcs_pkg::STAT_RESET;
      next_cpuRdata[fcs_pkg::STAT_TOGGLE_POS] = !toggleBit;
      next_cpuRdata[fcs_pkg::STAT_POLL_POS] = !arrayOpData[fcs_pkg::STAT_POLL_POS];
    end
    else if (cpuBus.rd)
      next_cpuRdata = arrayRdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      toggleBit <= 1'b0;
      cpuRdata <= 8'h00;
    end
    else
    begin
      toggleBit <= next_toggleBit;
      cpuRdata <= next_cpuRdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_unlock;
    @(posedge clk_sys) disable iff (!rst_n) ctlWrite && ctlField == fcs_pkg::CMD_UNLOCK |=> cmdUnlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("Unlock pattern did not enable commands");

  property p_locked_quiet;
    @(posedge clk_sys) disable iff (!rst_n) !cmdUnlocked |=> !arrayWrite && !arrayErase;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet) else $error("Array launched while locked");

  property p_lock;
    @(posedge clk_sys) disable iff (!rst_n) ctlWrite && ctlField == fcs_pkg::CMD_LOCK |=> !cmdUnlocked ##1 !arrayWrite;
  endproperty
  a_lock: assert property (p_lock) else $error("Lock pattern did not lock");

  property p_erase;
    @(posedge clk_sys) disable iff (!rst_n)
      state == fcs_pkg::ST_ERA5 && cmdUnlocked && flashSel && cpuBus.wr && cpuBus.wdata == fcs_pkg::CODE_SECTOR_ERASE
      |=> arrayErase && !arrayWrite && arrayOpAddr == 16'($past(cpuBus.addr) - fcs_pkg::FLASH_BASE) ##1 !arrayErase;
  endproperty
  a_erase: assert property (p_erase) else $error("Sector erase not launched");

  property p_write;
    @(posedge clk_sys) disable iff (!rst_n)
      state == fcs_pkg::ST_WR3 && cmdUnlocked && flashSel && cpuBus.wr
      |=> arrayWrite && arrayOpData == $past(cpuBus.wdata) && arrayOpBank == arrayOpAddr[fcs_pkg::BANK_BIT];
  endproperty
  a_write: assert property (p_write) else $error("Byte write not launched");

  property p_translate;
    @(posedge clk_sys) disable iff (!rst_n)
      state == fcs_pkg::ST_WR3 && cmdUnlocked && flashSel && cpuBus.wr
      |=> arrayOpAddr == 16'($past(cpuBus.addr) - fcs_pkg::FLASH_BASE);
  endproperty
  a_translate: assert property (p_translate) else $error("Write address not translated");

  property p_status_toggle;
    @(posedge clk_sys) disable iff (!rst_n) statusRead |=> cpuRdata[fcs_pkg::STAT_TOGGLE_POS] != $past(toggleBit);
  endproperty
  a_status_toggle: assert property (p_status_toggle) else $error("Status read did not toggle");

  property p_no_array_data;
    @(posedge clk_sys) disable iff (!rst_n)
      statusRead |=> cpuRdata[5:0] == fcs_pkg::STAT_RESET[5:0];
  endproperty
  a_no_array_data: assert property (p_no_array_data) else $error("Array data leaked during operation");

  property p_boot;
    @(posedge clk_sys) disable iff (!rst_n)
      cpuBus.rd && serialMode && cpuBus.addr >= fcs_pkg::BOOT_BASE && cpuBus.addr <= fcs_pkg::BOOT_LAST
      |=> cpuRdata == $past(bootRdata);
  endproperty
  a_boot: assert property (p_boot) else $error("Boot ROM window not decoded");

  property p_break;
    @(posedge clk_sys) disable iff (!rst_n)
      state == fcs_pkg::ST_CYC1 && cpuBus.wr && !hit(cpuBus, fcs_pkg::CMD_ADDR_B, fcs_pkg::CODE_SECOND)
      |=> state != fcs_pkg::ST_CYC2 && !arrayWrite && !arrayErase;
  endproperty
  a_break: assert property (p_break) else $error("Broken sequence not abandoned");

  c_erase: cover property (@(posedge clk_sys) disable iff (!rst_n) arrayErase ##[1:50] state == fcs_pkg::ST_IDLE);
  c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) arrayWrite);
  c_status: cover property (@(posedge clk_sys) disable iff (!rst_n) statusRead ##[1:5] statusRead);
  c_lock: cover property (@(posedge clk_sys) disable iff (!rst_n) cmdUnlocked ##1 !cmdUnlocked);

endmodule
`default_nettype wire
